/* File: design/sram_fifo_pkg.sv */
/*
 * package for the embedded sram / fifo block: geometry, register map,
 * field positions and reset values.
 * assumes a single 100 MHz clock and an apb master with 32-bit data.
 */
package sram_fifo_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int unsigned TOTAL_BITS = 4608;
  localparam int unsigned ADDR_W     = 12;              // 4k x 1 needs 12 bits

  // aspect codes: 0=4kx1 1=2kx2 2=1kx4 3=512x9 4=256x18
  typedef enum logic [2:0] {
    ASP_X1, ASP_X2, ASP_X4, ASP_X9, ASP_X18
  } aspect_t;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ALMOST_FULL_FLAG  = 8'h04;
  localparam logic [7:0] OFS_ALMOST_EMPTY_FLAG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ    = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  localparam logic [7:0] OFS_LDADDR = 8'h18;
  localparam logic [7:0] OFS_LDDATA = 8'h1C;
  localparam logic [7:0] OFS_COUNT  = 8'h20;

  // ctrl fields
  localparam int unsigned CTRL_WASP_LSB = 0;   // write aspect [2:0]
  localparam int unsigned CTRL_RASP_LSB = 4;   // read aspect  [6:4]
  localparam int unsigned CTRL_FIFO_BIT = 8;   // 1 = fifo mode
  localparam int unsigned CTRL_CLR_BIT  = 9;   // write 1: flush pointers
  localparam int unsigned ASP_W         = 3;

  // status / irq fields
  localparam int unsigned ST_EMPTY  = 0;
  localparam int unsigned ST_FULL   = 1;
  localparam int unsigned ST_ALMOST_EMPTY_FLAG = 2;
  localparam int unsigned ST_ALMOST_FULL_FLAG  = 3;
  localparam int unsigned IRQ_N     = 4;
  localparam int unsigned IRQ_OVF   = 0;       // write while full
  localparam int unsigned IRQ_UDF   = 1;       // read while empty
  localparam int unsigned IRQ_AF    = 2;       // almost full reached
  localparam int unsigned IRQ_AE    = 3;       // almost empty reached

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] ALMOST_FULL_FLAG_RST  = 32'h0000_0F00;
  localparam logic [31:0] ALMOST_EMPTY_FLAG_RST = 32'h0000_0100;
  localparam logic [31:0] BAD_ADDR   = 32'h0000_0000;

endpackage : sram_fifo_pkg

/* File: design/sram_array.sv */
/*
 * 4608-bit dual-port storage with independently sized ports.
 * assumes bit addressing: each port gives a bit base and a width.
 */
module sram_array #(
  parameter int unsigned BITS = 4608,
  parameter int unsigned AW   = 13
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] wbit_i,
  input  wire logic [4:0]    wlen_i,
  input  wire logic [17:0]   wdata_i,
  input  wire logic [AW-1:0] rbit_i,
  input  wire logic [4:0]    rlen_i,
  output logic      [17:0]   rdata_o
);
  // refuse an address too narrow for the array
  if (BITS > (1 << AW)) begin : g_bad_aw
    $error("sram_array: address too narrow");
  end

  logic mem [BITS];

  // ----------------------------------------------------------------
  // write port: one bit lane per data bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 18; i++) begin
      if (we_i && (5'(i) < wlen_i) && (32'(wbit_i) + i < BITS)) begin
        mem[32'(wbit_i) + i] <= wdata_i[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // read port: asynchronous gather, registered by the caller
  // ----------------------------------------------------------------
  always_comb begin
    rdata_o = '0;
    for (int i = 0; i < 18; i++) begin
      if ((5'(i) < rlen_i) && (32'(rbit_i) + i < BITS)) begin
        rdata_o[i] = mem[32'(rbit_i) + i];
      end
    end
  end

endmodule : sram_array

/* File: design/sram_fifo.sv */
/*
 * embedded sram block with built-in fifo controller, apb registers,
 * preload port and cascade flags.
 * assumes synchronous inputs on clk_i; apb master follows the protocol.
 */
// Behaviour
// - storage is 4608 bits in the x9 and x18 aspects, 4096 bits in x1 x2 x4
// - aspects 256x18 512x9 1kx4 2kx2 4kx1
// - independent read/write ports, separate widths outside fifo mode
// - 4-bit writes readable as 1-bit stream
// - preload from flash or test port
// - fifo controller built in
// - fifo width and depth configurable
// - full, empty, almost flags programmable
// - controller counters form address pointers
// - blocks cascade into deeper or wider
module sram_fifo
  import sram_fifo_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // user write port
  input  wire logic        wr_en_i,
  input  wire logic [17:0] wr_data_i,
  input  wire logic [11:0] wr_addr_i,
  // user read port
  input  wire logic        rd_en_i,
  input  wire logic [11:0] rd_addr_i,
  output logic      [17:0] rd_data_o,
  output logic             rd_valid_o,
  // preload from flash or test port access
  input  wire logic        load_en_i,
  input  wire logic [11:0] load_addr_i,
  input  wire logic [17:0] load_data_i,
  // fifo flags (also cascade hooks)
  output logic             full_o,
  output logic             empty_o,
  output logic             almost_full_flag_o,
  output logic             almost_empty_flag_o,
  output logic             irq_o
);
  import sram_fifo_pkg::*;

  localparam int unsigned BAW = 13;

  // width of an aspect code in bits
  function automatic logic [4:0] asp_width(input logic [2:0] a);
    case (a)
      ASP_X1:  asp_width = 5'd1;
      ASP_X2:  asp_width = 5'd2;
      ASP_X4:  asp_width = 5'd4;
      ASP_X9:  asp_width = 5'd9;
      ASP_X18: asp_width = 5'd18;
      default: asp_width = 5'd1;
    endcase
  endfunction : asp_width

  // depth of an aspect: 4608 bits / width, x1 x2 x4 use 4096 bits
  function automatic logic [12:0] asp_depth(input logic [2:0] a);
    case (a)
      ASP_X1:  asp_depth = 13'd4096;
      ASP_X2:  asp_depth = 13'd2048;
      ASP_X4:  asp_depth = 13'd1024;
      ASP_X9:  asp_depth = 13'd512;
      ASP_X18: asp_depth = 13'd256;
      default: asp_depth = 13'd4096;
    endcase
  endfunction : asp_depth

  // bit base of a word index in a given aspect
  function automatic logic [BAW-1:0] bit_base(input logic [11:0] idx, input logic [2:0] a);
    bit_base = BAW'(32'(idx) * 32'(asp_width(a)));
  endfunction : bit_base

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt, almost_full_flag_r, almost_full_flag_nxt, almost_empty_flag_r, almost_empty_flag_nxt;
  logic [31:0] mask_r, mask_nxt, prdata_r, prdata_nxt;
  logic [IRQ_N-1:0] irq_st_r, irq_st_nxt;
  logic [11:0] ldaddr_r, ldaddr_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [11:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic        full_r, full_nxt, empty_r, empty_nxt, af_r, af_nxt, ae_r, ae_nxt;
  logic        irq_r, irq_nxt, rdv_r, rdv_nxt;
  logic [17:0] rdata_r, rdata_nxt;

  logic [2:0]  wasp, rasp;
  logic        fifo_mode, apb_acc, apb_wr, apb_rd, sw_load;
  logic        do_wr, do_rd, mem_we;
  logic [BAW-1:0] wbit, rbit;
  logic [4:0]  wlen, rlen;
  logic [17:0] mem_wd, mem_rd;
  logic [12:0] depth;

  assign wasp      = ctrl_r[CTRL_WASP_LSB +: ASP_W];
  assign rasp      = ctrl_r[CTRL_RASP_LSB +: ASP_W];
  assign fifo_mode = ctrl_r[CTRL_FIFO_BIT];
  assign apb_acc   = psel_i && penable_i && !pready_r;
  assign apb_wr    = apb_acc && pwrite_i;
  assign apb_rd    = apb_acc && !pwrite_i;
  assign sw_load   = apb_wr && (paddr_i == OFS_LDDATA);
  // fifo depth follows the write aspect in words of that width
  assign depth     = asp_depth(wasp);

  // ----------------------------------------------------------------
  // fifo controller next state
  // ----------------------------------------------------------------
  always_comb begin
    do_wr    = fifo_mode && wr_en_i && !full_r;
    do_rd    = fifo_mode && rd_en_i && !empty_r;
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    cnt_nxt  = cnt_r;
    if (apb_wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_CLR_BIT]) begin
      wptr_nxt = '0;
      rptr_nxt = '0;
      cnt_nxt  = '0;
    end else begin
      // counters generate the memory addresses
      if (do_wr) begin
        wptr_nxt = (13'(wptr_r) + 13'd1 >= depth) ? 12'h000 : wptr_r + 12'h001;
      end
      if (do_rd) begin
        rptr_nxt = (13'(rptr_r) + 13'd1 >= depth) ? 12'h000 : rptr_r + 12'h001;
      end
      if (do_wr && !do_rd) cnt_nxt = cnt_r + 13'd1;
      if (do_rd && !do_wr) cnt_nxt = cnt_r - 13'd1;
    end
    full_nxt  = (cnt_nxt >= depth);
    empty_nxt = (cnt_nxt == 13'd0);
    af_nxt    = (32'(cnt_nxt) >= almost_full_flag_r);
    ae_nxt    = (32'(cnt_nxt) <= almost_empty_flag_r);
  end

  // ----------------------------------------------------------------
  // memory port muxing: load beats user write; fifo uses pointers
  // ----------------------------------------------------------------
  always_comb begin
    mem_we = 1'b0;
    wbit   = '0;
    wlen   = asp_width(wasp);
    mem_wd = wr_data_i;
    if (load_en_i) begin
      mem_we = 1'b1;
      wbit   = bit_base(load_addr_i, wasp);
      mem_wd = load_data_i;
    end else if (sw_load) begin
      mem_we = 1'b1;
      wbit   = bit_base(ldaddr_r, wasp);
      mem_wd = pwdata_i[17:0];
    end else if (fifo_mode) begin
      mem_we = do_wr;
      wbit   = bit_base(wptr_r, wasp);
    end else begin
      mem_we = wr_en_i;
      wbit   = bit_base(wr_addr_i, wasp);
    end
    rlen = fifo_mode ? asp_width(wasp) : asp_width(rasp);
    rbit = fifo_mode ? bit_base(rptr_r, wasp) : bit_base(rd_addr_i, rasp);
  end

  sram_array #(
    .BITS (TOTAL_BITS),
    .AW   (BAW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .wbit_i  (wbit),
    .wlen_i  (wlen),
    .wdata_i (mem_wd),
    .rbit_i  (rbit),
    .rlen_i  (rlen),
    .rdata_o (mem_rd)
  );

  // ----------------------------------------------------------------
  // read data, events and apb next state
  // ----------------------------------------------------------------
  always_comb begin
    rdv_nxt     = fifo_mode ? do_rd : rd_en_i;
    rdata_nxt   = (fifo_mode ? do_rd : rd_en_i) ? mem_rd : rdata_r;
    ctrl_nxt    = ctrl_r;
    almost_full_flag_nxt   = almost_full_flag_r;
    almost_empty_flag_nxt  = almost_empty_flag_r;
    mask_nxt    = mask_r;
    ldaddr_nxt  = ldaddr_r;
    irq_st_nxt  = irq_st_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = apb_acc;
    pslverr_nxt = 1'b0;
    if (apb_rd && paddr_i == OFS_IRQ) irq_st_nxt = '0;
    // set wins over the read clear
    if (fifo_mode && wr_en_i && full_r)  irq_st_nxt[IRQ_OVF] = 1'b1;
    if (fifo_mode && rd_en_i && empty_r) irq_st_nxt[IRQ_UDF] = 1'b1;
    if (af_nxt && !af_r) irq_st_nxt[IRQ_AF] = 1'b1;
    if (ae_nxt && !ae_r) irq_st_nxt[IRQ_AE] = 1'b1;
    if (apb_wr) begin
      case (paddr_i)
        OFS_CTRL:   ctrl_nxt   = pwdata_i & ~(32'h1 << CTRL_CLR_BIT);
        OFS_ALMOST_FULL_FLAG:  almost_full_flag_nxt  = pwdata_i;
        OFS_ALMOST_EMPTY_FLAG: almost_empty_flag_nxt = pwdata_i;
        OFS_MASK:   mask_nxt   = pwdata_i;
        OFS_LDADDR: ldaddr_nxt = pwdata_i[11:0];
        OFS_LDDATA: ldaddr_nxt = ldaddr_r + 12'h001;
        OFS_STATUS, OFS_IRQ, OFS_COUNT: ;
        default:    pslverr_nxt = 1'b1;
      endcase
    end
    if (apb_rd) begin
      case (paddr_i)
        OFS_CTRL:   prdata_nxt = ctrl_r;
        OFS_ALMOST_FULL_FLAG:  prdata_nxt = almost_full_flag_r;
        OFS_ALMOST_EMPTY_FLAG: prdata_nxt = almost_empty_flag_r;
        OFS_STATUS: prdata_nxt = {28'h0, af_r, ae_r, full_r, empty_r};
        OFS_IRQ:    prdata_nxt = {28'h0, irq_st_r};
        OFS_MASK:   prdata_nxt = mask_r;
        OFS_LDADDR: prdata_nxt = {20'h0, ldaddr_r};
        OFS_COUNT:  prdata_nxt = {19'h0, cnt_r};
        default: begin
          prdata_nxt  = BAD_ADDR;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    irq_nxt = |(irq_st_nxt & mask_nxt[IRQ_N-1:0]);
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r    <= CTRL_RST;
      almost_full_flag_r   <= ALMOST_FULL_FLAG_RST;
      almost_empty_flag_r  <= ALMOST_EMPTY_FLAG_RST;
      mask_r    <= '0;
      ldaddr_r  <= '0;
      irq_st_r  <= '0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      wptr_r    <= '0;
      rptr_r    <= '0;
      cnt_r     <= '0;
      full_r    <= 1'b0;
      empty_r   <= 1'b1;
      af_r      <= 1'b0;
      ae_r      <= 1'b1;
      irq_r     <= 1'b0;
      rdv_r     <= 1'b0;
      rdata_r   <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      almost_full_flag_r   <= almost_full_flag_nxt;
      almost_empty_flag_r  <= almost_empty_flag_nxt;
      mask_r    <= mask_nxt;
      ldaddr_r  <= ldaddr_nxt;
      irq_st_r  <= irq_st_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      wptr_r    <= wptr_nxt;
      rptr_r    <= rptr_nxt;
      cnt_r     <= cnt_nxt;
      full_r    <= full_nxt;
      empty_r   <= empty_nxt;
      af_r      <= af_nxt;
      ae_r      <= ae_nxt;
      irq_r     <= irq_nxt;
      rdv_r     <= rdv_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // flags drive cascade logic outside the block
  assign full_o              = full_r;
  assign empty_o             = empty_r;
  assign almost_full_flag_o  = af_r;
  assign almost_empty_flag_o = ae_r;
  assign irq_o               = irq_r;
  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;
  assign rd_data_o           = rdata_r;
  assign rd_valid_o          = rdv_r;

endmodule : sram_fifo

/* File: tb/sram_fifo_checker.sv */
/* port-level assertions for the sram / fifo block.
   assumes it is bound to sram_fifo, one clock, sync active-high reset. */
module sram_fifo_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic rd_valid_o,
  input wire logic full_o,
  input wire logic empty_o,
  input wire logic almost_empty_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // bus answer timing
  // ------------------------------------------------------------
  AST_APB_ANSWER: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered next cycle");
  AST_APB_CAUSE: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error outside ready");
  // ------------------------------------------------------------
  // flags and pointers
  // ------------------------------------------------------------
  AST_FLAGS_EXCL: assert property (!(full_o && empty_o))
    else $error("full and empty together");
  AST_AE_WHEN_EMPTY: assert property (empty_o |-> almost_empty_flag_o)
    else $error("empty without almost empty");
  AST_EMPTY_CAUSE: assert property ($rose(empty_o) |-> $past(rd_en_i || psel_i))
    else $error("empty rose without read");
  AST_FULL_CAUSE: assert property ($rose(full_o) |-> $past(wr_en_i || psel_i))
    else $error("full rose without write");
  AST_FULL_HOLD: assert property (full_o && wr_en_i && !rd_en_i && !psel_i |=> full_o)
    else $error("write while full moved pointers");
  AST_EMPTY_HOLD: assert property (empty_o && rd_en_i && !wr_en_i && !psel_i |=> empty_o)
    else $error("read while empty moved pointers");
  AST_VALID_CAUSE: assert property (rd_valid_o |-> $past(rd_en_i))
    else $error("read valid without request");
  // main scenarios reached
  cover property (psel_i && penable_i ##1 pready_o);
  cover property ($rose(full_o));
  cover property (empty_o && rd_en_i);
endmodule : sram_fifo_checker

bind sram_fifo sram_fifo_checker sram_fifo_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .rd_valid_o(rd_valid_o), .full_o(full_o), .empty_o(empty_o),
  .almost_empty_flag_o(almost_empty_flag_o));

/* File: tb/fabric_user_model.sv */
/* fabric user logic on the block's write and read ports.
   assumes registered read answers and one request per task call. */
module fabric_user_model (
  input  wire logic        clk_i,
  input  wire logic [17:0] rd_data_i,
  input  wire logic        rd_valid_i,
  output logic             wr_en_o,
  output logic      [17:0] wr_data_o,
  output logic      [11:0] wr_addr_o,
  output logic             rd_en_o,
  output logic      [11:0] rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_en_o = 1'b0;
    wr_data_o = 18'h00000;
    wr_addr_o = 12'h000;
    rd_en_o = 1'b0;
    rd_addr_o = 12'h000;
  end
  // one write; data and address scrambled once released
  task automatic put(input logic [11:0] a, input logic [17:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
  endtask : put
  // one read, independent of the write side; ok low if no answer
  task automatic get(input logic [11:0] a, output logic [17:0] q, output logic ok);
    int k;
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~a;
    ok = 1'b0;
    q = 18'h00000;
    for (k = 0; k < 3 && !ok; k++) begin
      @(negedge clk_i);
      if (rd_valid_i === 1'b1) begin
        ok = 1'b1;
        q = rd_data_i;
      end
    end
  endtask : get
endmodule : fabric_user_model

/* File: tb/embedded_sram_fifo_block_tb.sv */
/* self-checking bench for the sram / fifo block.
   assumes the fabric user model and the bound checker. */
module embedded_sram_fifo_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_fifo_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o;
  logic pready_o, pslverr_o, wr_en_i, rd_en_i, rd_valid_o, irq_o;
  logic full_o, empty_o, almost_full_flag_o, almost_empty_flag_o;
  logic [17:0] wr_data_i, rd_data_o;
  logic [11:0] wr_addr_i, rd_addr_i;
  logic load_en_i = 1'b0;
  logic [11:0] load_addr_i = 12'h000;
  logic [17:0] load_data_i = 18'h00000;
  int n_errors = 0, tests_run = 0;
  sram_fifo sram_fifo_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i), .wr_addr_i(wr_addr_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .load_en_i(load_en_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i), .full_o(full_o), .empty_o(empty_o),
    .almost_full_flag_o(almost_full_flag_o), .almost_empty_flag_o(almost_empty_flag_o),
    .irq_o(irq_o));
  fabric_user_model fabric_user_model_inst (.clk_i(clk_i), .rd_data_i(rd_data_o),
    .rd_valid_i(rd_valid_o), .wr_en_o(wr_en_i), .wr_data_o(wr_data_i),
    .wr_addr_o(wr_addr_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one apb transfer; waits for ready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 8; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (k == 8) begin
      n_errors++;
      report_and_stop();
    end else begin
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask : apb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(what, {q[31:1], q[0] | e}, exp);
  endtask : rreg
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_regs;
    rreg(OFS_CTRL, CTRL_RST, "ctrl reset");
    rreg(OFS_ALMOST_FULL_FLAG, ALMOST_FULL_FLAG_RST, "almost_full_flag thr reset");
    rreg(OFS_ALMOST_EMPTY_FLAG, ALMOST_EMPTY_FLAG_RST, "almost_empty_flag thr reset");
    wreg(OFS_STATUS, 32'h0000_000F);
    rreg(OFS_STATUS, 32'h0000_0005, "status ro");
    rreg(8'h40, 32'h0000_0001, "unmapped err");
    $display("test reset_regs done");
  endtask : t_reset_regs
  task automatic t_ram_aspect;
    logic [17:0] q;
    logic ok;
    wreg(OFS_CTRL, 32'h0000_0002); // nibble writes, bit reads
    fabric_user_model_inst.put(12'h000, 18'h0000A);
    fabric_user_model_inst.put(12'h001, 18'h00003);
    for (int k = 0; k < 8; k++) begin
      fabric_user_model_inst.get(12'(k), q, ok);
      check("serial bit", {ok, q[0]}, {1'b1, 1'(8'h3A >> k)});
    end
    wreg(OFS_CTRL, 32'h0000_0033); // nine-bit words on both ports
    fabric_user_model_inst.put(12'h003, 18'h001A5);
    fabric_user_model_inst.get(12'h003, q, ok);
    check("x9 word", {ok, q}, {1'b1, 18'h001A5});
    $display("test ram_aspect done");
  endtask : t_ram_aspect
  task automatic t_preload;
    logic [17:0] q;
    logic ok;
    wreg(OFS_CTRL, 32'h0000_0044);
    wreg(OFS_LDADDR, 32'h0000_0005);
    wreg(OFS_LDDATA, 32'h0002_ABCD);
    wreg(OFS_LDDATA, 32'h0000_1234);
    fabric_user_model_inst.get(12'h005, q, ok);
    check("preload word", {ok, q}, {1'b1, 18'h2ABCD});
    fabric_user_model_inst.get(12'h006, q, ok);
    check("preload incr", {ok, q}, {1'b1, 18'h01234});
    // one-cycle strobe on the flash / test port load path
    @(posedge clk_i);
    load_en_i <= 1'b1;
    load_addr_i <= 12'h007;
    load_data_i <= 18'h15A5A;
    @(posedge clk_i);
    load_en_i <= 1'b0;
    fabric_user_model_inst.get(12'h007, q, ok);
    check("strobe load", {ok, q}, {1'b1, 18'h15A5A});
    $display("test preload done");
  endtask : t_preload
  task automatic t_fifo;
    logic [17:0] q;
    logic ok, m0;
    wreg(OFS_CTRL, 32'h0000_0344);
    wreg(OFS_ALMOST_FULL_FLAG, 32'h0000_0003);
    wreg(OFS_ALMOST_EMPTY_FLAG, 32'h0000_0001);
    wreg(OFS_MASK, 32'h0000_0000);
    rreg(OFS_IRQ, 32'h0000_0000, "irq idle");
    for (int k = 1; k <= 257; k++) begin
      fabric_user_model_inst.put(12'h000, 18'(k * 32'h0000_0155));
      @(negedge clk_i);
      check("full", full_o, k >= 256);
      check("almost full", almost_full_flag_o, k >= 3);
      check("almost empty", almost_empty_flag_o, k <= 1);
    end
    rreg(OFS_COUNT, 32'h0000_0100, "count at full");
    rreg(OFS_STATUS, 32'h0000_000A, "status full");
    m0 = irq_o;
    wreg(OFS_MASK, 32'h0000_000F);
    @(negedge clk_i);
    check("mask effect", m0 ^ irq_o, 32'h0000_0001);
    rreg(OFS_IRQ, 32'h0000_0005, "overflow event");
    @(negedge clk_i);
    check("irq cleared", irq_o, 32'h0000_0000);
    for (int k = 1; k <= 257; k++) begin
      fabric_user_model_inst.get(12'h000, q, ok);
      check("pop", {ok, q}, k > 256 ? 0 : {1'b1, 18'(k * 32'h0000_0155)});
      check("empty", empty_o, k >= 256);
      check("almost empty pop", almost_empty_flag_o, k >= 255);
    end
    rreg(OFS_IRQ, 32'h0000_000A, "underflow event");
    $display("test fifo done");
  endtask : t_fifo
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_regs();
    t_ram_aspect();
    t_preload();
    t_fifo();
    report_and_stop();
  end
endmodule : embedded_sram_fifo_block_tb
